// [hdl/bocs_supervisor.sv]
// overcurrent supervisor of a two-phase boost controller
// Functional notes
// - peak limit hit turns off that phase low-side gate for the cycle
// - below negative limit turns off that phase high-side gate, no shutdown
// - second peak threshold three consecutive cycles on a phase raises peak fault
// - peak and average fault detection armed from soft-start onward
// - peak fault sets status bit 5 and drives alert low
// - average monitor above threshold sets status bit 4 and alert low
// - unmasked fault stops all switching, enters hiccup or latch-off per setting
// - mask bits reset to zero; masked fault only flags, switching continues
// - hiccup peak fault resumes via soft-start once no phase trips
// - hiccup average fault resumes via soft-start once monitor drops below
// - status bits stay set; alert low while any set
// - status cleared only by write, clear command, enable toggle, or reset
// - alert released only when every status bit is zero
// - average fault threshold selectable among eight settings, default first
// - constant-current reference selectable among eight, default highest setting
// - constant-current loop active from soft-start onward
// - latch-off keeps switching off until reset or an enable toggle; registers stay usable
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "bocs_regs.svh"

module bocs_supervisor
   import bocs_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     cycle_start,
   input  wire logic                     enable,
   input  wire bocs_phase_cmp_t [1:0]    phase_current_sense,
   input  wire logic                     avg_overcurrent_comparator,
   input  wire logic [`BOCS_ADDR_W-1:0]  addr,
   input  wire logic [7:0]               wdata,
   input  wire logic                     wr,
   input  wire logic                     rd,
   output logic      [7:0]               rdata,
   output bocs_gate_t [1:0]              gate_enable,
   output logic                          switching_en,
   output logic                          constant_current_loop,
   output logic      [2:0]               avg_overcurrent_threshold_cmd,
   output logic      [2:0]               const_current_ref_cmd,
   output logic                          alert_n,
   output logic                          irq
);

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   logic [8:0] sync1_q;
   logic [8:0] sync2_q;
   wire  [8:0] raw_in = {enable, avg_overcurrent_comparator, cycle_start,
                         phase_current_sense[1], phase_current_sense[0]};

   // two flops before any logic sees the pins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync1_q <= 9'h000;
         sync2_q <= 9'h000;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end

   bocs_phase_cmp_t [1:0] cmp;
   wire logic en_s    = sync2_q[8];
   wire logic avg_s   = sync2_q[7];
   wire logic cyc_s   = sync2_q[6];
   assign cmp[1]      = sync2_q[5:3];
   assign cmp[0]      = sync2_q[2:0];

   // cycle boundary is the rising edge of the synchronised cycle marker
   logic cyc_d1_q;
   wire logic cyc_edge = cyc_s & ~cyc_d1_q;

   // ****************************************************************
   // register file
   // ****************************************************************
   logic [7:0]  status_q;
   logic [7:0]  mask_q;
   logic [7:0]  resp_q;
   logic [2:0]  avg_thr_q;
   logic [2:0]  cc_ref_q;
   bocs_state_t state_q;
   bocs_state_t state_d;
   logic [7:0]  ss_cnt_q;
   logic [1:0]  peak_cnt_q [1:0];
   logic        en_d1_q;

   wire logic wr_status = wr && (addr == `BOCS_OFS_STATUS);
   wire logic wr_mask   = wr && (addr == `BOCS_OFS_MASK);
   wire logic wr_resp   = wr && (addr == `BOCS_OFS_RESPONSE);
   wire logic wr_avg    = wr && (addr == `BOCS_OFS_AVG_THR);
   wire logic wr_cc     = wr && (addr == `BOCS_OFS_CC_REF);
   wire logic wr_cmd    = wr && (addr == `BOCS_OFS_CMD);
   wire logic clear_all = wr_cmd && wdata[`BOCS_BIT_CMD_CLEAR];

   // enable toggle restarts state, counters and status, as a reset would; settings are kept
   wire logic en_toggle = en_s ^ en_d1_q;

   // ****************************************************************
   // fault detection
   // ****************************************************************
   // detection is armed whenever enabled, soft-start included
   wire logic armed = en_s;

   logic [1:0] peak_hit;
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_phase
         // third consecutive cycle at the second threshold
         assign peak_hit[g] = cyc_edge && cmp[g].peak_fault_level &&
                              (peak_cnt_q[g] == `BOCS_PEAK_CYCLES - 2'h1);

         // counter advances per cycle and clears on a miss
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               peak_cnt_q[g] <= 2'h0;
            end else if (!armed || en_toggle) begin
               peak_cnt_q[g] <= 2'h0;
            end else if (cyc_edge) begin
               if (!cmp[g].peak_fault_level) begin
                  peak_cnt_q[g] <= 2'h0;
               end else if (peak_cnt_q[g] != `BOCS_PEAK_CYCLES) begin
                  peak_cnt_q[g] <= peak_cnt_q[g] + 2'h1;
               end
            end
         end
      end
   endgenerate

   wire logic peak_evt = armed && (|peak_hit);
   wire logic avg_evt  = armed && avg_s;

   wire logic [7:0] set_bits = ({7'h00, peak_evt} << `BOCS_BIT_PEAK) |
                               ({7'h00, avg_evt}  << `BOCS_BIT_AVG);

   // unmasked events shut switching down
   wire logic peak_trip = peak_evt && !mask_q[`BOCS_BIT_PEAK];
   wire logic avg_trip  = avg_evt  && !mask_q[`BOCS_BIT_AVG];
   wire logic any_trip  = peak_trip || avg_trip;
   wire logic latch_sel = (peak_trip && resp_q[`BOCS_BIT_RESP_PEAK]) ||
                          (avg_trip  && resp_q[`BOCS_BIT_RESP_AVG]);

   // still tripping: any phase at the second threshold, or monitor high
   wire logic peak_now  = cmp[0].peak_fault_level || cmp[1].peak_fault_level;
   wire logic still_bad = peak_now || avg_s;

   // ****************************************************************
   // state machine
   // ****************************************************************
   always_comb begin
      state_d = state_q;
      case (state_q)
         BOCS_SOFT_START: begin
            if (any_trip) begin
               state_d = latch_sel ? BOCS_LATCHED : BOCS_HICCUP;
            end else if (ss_cnt_q == `BOCS_HICCUP_SS_CYCLES) begin
               state_d = BOCS_RUN;
            end
         end
         BOCS_RUN: begin
            if (any_trip) begin
               state_d = latch_sel ? BOCS_LATCHED : BOCS_HICCUP;
            end
         end
         BOCS_HICCUP: begin
            if (!still_bad) begin
               state_d = BOCS_SOFT_START;
            end
         end
         BOCS_LATCHED: begin
            state_d = BOCS_LATCHED;
         end
         default: begin
            state_d = BOCS_SOFT_START;
         end
      endcase
   end

   // state, soft-start cycle count, enable and edge history
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q  <= BOCS_SOFT_START;
         ss_cnt_q <= 8'h00;
         en_d1_q  <= 1'b0;
         cyc_d1_q <= 1'b0;
      end else begin
         en_d1_q  <= en_s;
         cyc_d1_q <= cyc_s;
         if (en_toggle || !en_s) begin
            state_q  <= BOCS_SOFT_START;
            ss_cnt_q <= 8'h00;
         end else begin
            state_q <= state_d;
            if (state_d != BOCS_SOFT_START) begin
               ss_cnt_q <= 8'h00;
            end else if (cyc_edge && ss_cnt_q != `BOCS_HICCUP_SS_CYCLES) begin
               ss_cnt_q <= ss_cnt_q + 8'h01;
            end
         end
      end
   end

   // ****************************************************************
   // registers: sticky status, mask, response, thresholds
   // ****************************************************************
   // set wins over a clear in the same cycle; only writes, command, enable toggle or reset clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status_q  <= 8'h00;
         mask_q    <= `BOCS_MASK_RST;
         resp_q    <= `BOCS_RESP_RST;
         avg_thr_q <= `BOCS_AVG_THR_RST;
         cc_ref_q  <= `BOCS_CC_REF_RST;
      end else begin
         if (en_toggle || clear_all) begin
            status_q <= set_bits;
         end else if (wr_status) begin
            status_q <= (status_q & ~wdata) | set_bits;
         end else begin
            status_q <= status_q | set_bits;
         end
         if (wr_mask) begin
            mask_q <= wdata;
         end
         if (wr_resp) begin
            resp_q <= wdata;
         end
         if (wr_avg) begin
            avg_thr_q <= wdata[2:0];
         end
         if (wr_cc) begin
            cc_ref_q <= wdata[2:0];
         end
      end
   end

   // ****************************************************************
   // register read port, data one cycle after the strobe
   // ****************************************************************
   logic [7:0] rdata_d;
   always_comb begin
      case (addr)
         `BOCS_OFS_STATUS:   rdata_d = status_q;
         `BOCS_OFS_MASK:     rdata_d = mask_q;
         `BOCS_OFS_RESPONSE: rdata_d = resp_q;
         `BOCS_OFS_AVG_THR:  rdata_d = {5'h00, avg_thr_q};
         `BOCS_OFS_CC_REF:   rdata_d = {5'h00, cc_ref_q};
         `BOCS_OFS_STATE:    rdata_d = {6'h00, state_q};
         default:            rdata_d = 8'h00;
      endcase
   end

   // unmapped reads and idle cycles return zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rd ? rdata_d : 8'h00;
      end
   end

   // ****************************************************************
   // gate permissions and outputs
   // ****************************************************************
   logic [1:0] lo_cut_q;
   logic [1:0] hi_cut_q;
   wire logic  run_ok = en_s && (state_q == BOCS_RUN || state_q == BOCS_SOFT_START);

   // cycle-by-cycle cuts hold until the next cycle starts; no shutdown involved
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lo_cut_q <= 2'h0;
         hi_cut_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (cmp[i].peak_cycle_limit) begin
               lo_cut_q[i] <= 1'b1;
            end else if (cyc_edge) begin
               lo_cut_q[i] <= 1'b0;
            end
            if (cmp[i].negative_cycle_limit) begin
               hi_cut_q[i] <= 1'b1;
            end else if (cyc_edge) begin
               hi_cut_q[i] <= 1'b0;
            end
         end
      end
   end

   // a comparator trip cuts its gate at once, the flop carries it to cycle end
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         gate_enable[i].low_side_gate  = run_ok && !lo_cut_q[i] &&
                                         !cmp[i].peak_cycle_limit;
         gate_enable[i].high_side_gate = run_ok && !hi_cut_q[i] &&
                                         !cmp[i].negative_cycle_limit;
      end
   end

   assign switching_en                  = run_ok;
   assign constant_current_loop         = run_ok;
   assign avg_overcurrent_threshold_cmd = avg_thr_q;
   assign const_current_ref_cmd         = cc_ref_q;
   assign alert_n                       = ~(|status_q);
   assign irq                           = |(status_q & ~mask_q);

endmodule

// [include/bocs_regs.svh]
// register offsets, field positions, reset values and timing counts of the overcurrent supervisor
`ifndef BOCS_REGS_SVH
`define BOCS_REGS_SVH
// ****************************************************************
// register offsets (word index on the plain register port)
// ****************************************************************
`define BOCS_ADDR_W            4
`define BOCS_OFS_STATUS        4'h0
`define BOCS_OFS_MASK          4'h1
`define BOCS_OFS_RESPONSE      4'h2
`define BOCS_OFS_AVG_THR       4'h3
`define BOCS_OFS_CC_REF        4'h4
`define BOCS_OFS_CMD           4'h5
`define BOCS_OFS_STATE         4'h6
// ****************************************************************
// field positions and reset values
// ****************************************************************
`define BOCS_BIT_AVG           4
`define BOCS_BIT_PEAK          5
`define BOCS_BIT_RESP_PEAK     0
`define BOCS_BIT_RESP_AVG      1
`define BOCS_BIT_CMD_CLEAR     0
`define BOCS_MASK_RST          8'h00
`define BOCS_RESP_RST          8'h00
`define BOCS_AVG_THR_RST       3'h0
`define BOCS_CC_REF_RST        3'h7
// ****************************************************************
// timing counts, in switching cycles
// ****************************************************************
`define BOCS_PEAK_CYCLES       2'h3
`define BOCS_HICCUP_SS_CYCLES  8'h40
`endif

// [include/bocs_pkg.sv]
// types of the overcurrent supervisor
package bocs_pkg;
   // ****************************************************************
   // supervisor state, gray coded in the order soft-start, run, hiccup, latched
   // ****************************************************************
   typedef enum logic [1:0] {
      BOCS_SOFT_START = 2'h0,
      BOCS_RUN        = 2'h1,
      BOCS_HICCUP     = 2'h3,
      BOCS_LATCHED    = 2'h2
   } bocs_state_t;

   // per-phase comparator results
   typedef struct packed {
      logic peak_cycle_limit;
      logic negative_cycle_limit;
      logic peak_fault_level;
   } bocs_phase_cmp_t;

   // per-phase gate permissions
   typedef struct packed {
      logic low_side_gate;
      logic high_side_gate;
   } bocs_gate_t;
endpackage

// [testbench/bocs_supervisor_asserts.sv]
// port checker of the overcurrent supervisor
`timescale 1ns/1ps
`include "bocs_regs.svh"
module bocs_supervisor_asserts
   import bocs_pkg::*;
(
   input wire logic                     clk,
   input wire logic                     rst_n,
   input wire logic                     enable,
   input wire bocs_phase_cmp_t [1:0]    phase_current_sense,
   input wire logic [`BOCS_ADDR_W-1:0]  addr,
   input wire logic                     wr,
   input wire logic                     rd,
   input wire logic [7:0]               rdata,
   input wire bocs_gate_t [1:0]         gate_enable,
   input wire logic                     switching_en,
   input wire logic                     constant_current_loop,
   input wire logic [2:0]               avg_overcurrent_threshold_cmd,
   input wire logic [2:0]               const_current_ref_cmd,
   input wire logic                     alert_n,
   input wire logic                     irq
);
   // ****************
   // properties
   // ****************
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [3:0] en_hist_q;
   wire        en_quiet;
   // a toggle of enable clears status only after the synchroniser
   assign en_quiet = (en_hist_q == {4{enable}});
   always_ff @(posedge clk) en_hist_q <= {en_hist_q[2:0], enable};

   a_cc_tracks_sw: assert property (constant_current_loop == switching_en)
      else $error("cc loop differs from switching enable");
   a_stop_gates: assert property (!switching_en |-> gate_enable == '0)
      else $error("gate permission while switching stopped");
   a_peak_cut: assert property ($past(phase_current_sense[0].peak_cycle_limit, 2)
      |-> !gate_enable[0].low_side_gate) else $error("low side kept after peak limit");
   a_neg_cut: assert property ($past(phase_current_sense[1].negative_cycle_limit, 2)
      |-> !gate_enable[1].high_side_gate) else $error("high side kept after neg limit");
   a_irq_alert: assert property (irq |-> !alert_n)
      else $error("interrupt without alert");
   a_alert_holds: assert property (!alert_n && !wr && en_quiet |=> !alert_n)
      else $error("alert released without a clearing cause");
   a_status_alert: assert property (rd && addr == `BOCS_OFS_STATUS
      |=> (rdata != 8'h00) == !$past(alert_n)) else $error("alert disagrees with status");
   a_cmd_defaults: assert property ($rose(rst_n) |->
      avg_overcurrent_threshold_cmd == `BOCS_AVG_THR_RST && const_current_ref_cmd == 3'h7)
      else $error("setting defaults wrong after reset");
endmodule
bind bocs_supervisor bocs_supervisor_asserts u_chk (.clk(clk), .rst_n(rst_n),
   .enable(enable), .phase_current_sense(phase_current_sense), .addr(addr), .wr(wr),
   .rd(rd), .rdata(rdata), .gate_enable(gate_enable), .switching_en(switching_en),
   .constant_current_loop(constant_current_loop), .irq(irq), .alert_n(alert_n),
   .avg_overcurrent_threshold_cmd(avg_overcurrent_threshold_cmd),
   .const_current_ref_cmd(const_current_ref_cmd));

// [testbench/bocs_stage.sv]
// power stage and current sense model facing the supervisor
`timescale 1ns/1ps
module bocs_stage
   import bocs_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             switching_en,
   input  wire logic [1:0]       lim_req,
   input  wire logic [1:0]       neg_req,
   input  wire logic [1:0]       flt_req,
   input  wire logic             avg_req,
   output logic                  cycle_start,
   output bocs_phase_cmp_t [1:0] phase_current_sense,
   output logic                  avg_overcurrent_comparator
);
   logic [2:0] cyc_q = 3'h0;
   // switching clock runs free: eight system clocks, high first half
   always_ff @(posedge clk) cyc_q <= cyc_q + 3'h1;
   assign cycle_start = !cyc_q[2];
   // limit sits above the cc level, so it trips only on real overload
   // with gates off no ramp exists, so cycle limits cannot trip
   assign phase_current_sense[0] = '{lim_req[0] & switching_en,
                                     neg_req[0] & switching_en, flt_req[0]};
   assign phase_current_sense[1] = '{lim_req[1] & switching_en,
                                     neg_req[1] & switching_en, flt_req[1]};
   assign avg_overcurrent_comparator = avg_req;
endmodule

// [testbench/bocs_supervisor_bench.sv]
// self-checking bench of the overcurrent supervisor
`timescale 1ns/1ps
`include "bocs_regs.svh"
module bocs_supervisor_bench
   import bocs_pkg::*;
;
   typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} bocs_row_t;
   logic clk = 1'h0, rst_n = 1'h0, enable = 1'h0, wr = 1'h0, rd = 1'h0, avg_req = 1'h0;
   logic [3:0]            addr = 4'h0;
   logic [7:0]            wdata = 8'h00, rdata;
   logic [1:0]            lim_req = 2'h0, neg_req = 2'h0, flt_req = 2'h0;
   logic                  cyc_st, sw_en, cc_on, alert_n, irq, avg_cmp;
   logic [2:0]            thr_cmd, ref_cmd;
   bocs_phase_cmp_t [1:0] pcs;
   bocs_gate_t [1:0]      gates;
   int                    mismatches = 0, num_checks = 0;
   bocs_row_t rows [5] = '{'{4'h1, 8'h30, 8'h30}, '{4'h2, 8'h03, 8'h03},
      '{4'h7, 8'hA5, 8'h00}, '{4'h1, 8'h00, 8'h00}, '{4'h2, 8'h00, 8'h00}};
   always #25 clk = ~clk;
   bocs_supervisor dut (.clk(clk), .rst_n(rst_n), .cycle_start(cyc_st), .enable(enable),
      .phase_current_sense(pcs), .avg_overcurrent_comparator(avg_cmp), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gate_enable(gates),
      .switching_en(sw_en), .constant_current_loop(cc_on), .alert_n(alert_n),
      .avg_overcurrent_threshold_cmd(thr_cmd), .const_current_ref_cmd(ref_cmd), .irq(irq));
   bocs_stage u_stage (.clk(clk), .switching_en(sw_en), .lim_req(lim_req),
      .neg_req(neg_req), .flt_req(flt_req), .avg_req(avg_req), .cycle_start(cyc_st),
      .phase_current_sense(pcs), .avg_overcurrent_comparator(avg_cmp));
   // ****************
   // tasks
   // ****************
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   // read data stand only in the cycle after the strobe; taken at the edge ending it
   task automatic rd_chk(input string n, input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      @(posedge clk);
      chk(n, e, rdata);
   endtask
   task automatic wait_sw(input logic e, input int lim);
      int i;
      for (i = 0; i < lim && sw_en !== e; i++) @(posedge clk);
      chk("switching_en", {7'h0, e}, {7'h0, sw_en});
      if (sw_en !== e) conclude();
   endtask
   // returns mid-period, so level changes never race a cycle edge
   task automatic cyc(input int n);
      int k;
      repeat (n) begin
         k = 0;
         do begin
            @(posedge clk);
            k++;
         end while (u_stage.cyc_q !== 3'h3 && k < 9);
         if (k == 9) chk("cycle_start", 8'h01, 8'h00);
      end
   endtask
   // ****************
   // sequence
   // ****************
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      chk("avg_thr_cmd", 8'h00, {5'h0, thr_cmd});
      chk("cc_ref_cmd", 8'h07, {5'h0, ref_cmd});
      rd_chk("mask", `BOCS_OFS_MASK, 8'h00);
      enable <= 1'h1;
      wait_sw(1'h1, 20);
      chk("cc_loop", 8'h01, {7'h0, cc_on});
      foreach (rows[i]) begin
         wr_reg(rows[i].a, rows[i].d);
         rd_chk("row", rows[i].a, rows[i].e);
      end
      for (int i = 0; i < 8; i++) begin
         wr_reg(`BOCS_OFS_AVG_THR, 8'(i));
         wr_reg(`BOCS_OFS_CC_REF, 8'(7 - i));
         @(posedge clk);
         chk("avg_thr_cmd", 8'(i), {5'h0, thr_cmd});
         chk("cc_ref_cmd", 8'(7 - i), {5'h0, ref_cmd});
      end
      // average fault while still in soft-start, hiccup response
      rd_chk("state", `BOCS_OFS_STATE, 8'h00);
      avg_req <= 1'h1;
      wait_sw(1'h0, 20);
      rd_chk("status", `BOCS_OFS_STATUS, 8'h10);
      chk("irq", 8'h01, {7'h0, irq});
      rd_chk("state", `BOCS_OFS_STATE, 8'h03);
      chk("cc_loop", 8'h00, {7'h0, cc_on});
      avg_req <= 1'h0;
      wait_sw(1'h1, 100);
      chk("alert_n", 8'h00, {7'h0, alert_n});
      wr_reg(`BOCS_OFS_CMD, 8'h01);
      @(posedge clk);
      chk("alert_n", 8'h01, {7'h0, alert_n});
      // cycle limits cut one gate of one phase only
      cyc(1);
      lim_req <= 2'h1;
      cyc(1);
      chk("gates", 8'h0D, {4'h0, gates});
      lim_req <= 2'h0;
      neg_req <= 2'h2;
      cyc(1);
      chk("gates", 8'h0B, {4'h0, gates});
      neg_req <= 2'h0;
      cyc(2);
      chk("gates", 8'h0F, {4'h0, gates});
      // two high cycles, a gap, two more: never three in a row
      flt_req <= 2'h2;
      cyc(2);
      flt_req <= 2'h0;
      cyc(1);
      flt_req <= 2'h2;
      cyc(2);
      flt_req <= 2'h0;
      cyc(1);
      rd_chk("status", `BOCS_OFS_STATUS, 8'h00);
      // align to a cycle so exactly three cycle edges see the level
      cyc(1);
      flt_req <= 2'h2;
      cyc(3);
      repeat (4) @(posedge clk);
      chk("switching_en", 8'h00, {7'h0, sw_en});
      rd_chk("status", `BOCS_OFS_STATUS, 8'h20);
      chk("alert_n", 8'h00, {7'h0, alert_n});
      rd_chk("state", `BOCS_OFS_STATE, 8'h03);
      flt_req <= 2'h0;
      wait_sw(1'h1, 100);
      rd_chk("status", `BOCS_OFS_STATUS, 8'h20);
      wr_reg(`BOCS_OFS_STATUS, 8'h20);
      rd_chk("status", `BOCS_OFS_STATUS, 8'h00);
      // hiccup soft-start runs its full length, then normal running
      repeat (530) @(posedge clk);
      rd_chk("state", `BOCS_OFS_STATE, 8'h01);
      chk("cc_loop", 8'h01, {7'h0, cc_on});
      // masked average fault only flags
      wr_reg(`BOCS_OFS_MASK, 8'h30);
      avg_req <= 1'h1;
      repeat (8) @(posedge clk);
      chk("switching_en", 8'h01, {7'h0, sw_en});
      chk("irq", 8'h00, {7'h0, irq});
      chk("alert_n", 8'h00, {7'h0, alert_n});
      avg_req <= 1'h0;
      repeat (4) @(posedge clk);
      wr_reg(`BOCS_OFS_CMD, 8'h01);
      wr_reg(`BOCS_OFS_MASK, 8'h00);
      // latch-off holds until an enable toggle
      wr_reg(`BOCS_OFS_RESPONSE, 8'h01);
      cyc(1);
      flt_req <= 2'h1;
      cyc(3);
      flt_req <= 2'h0;
      cyc(3);
      rd_chk("state", `BOCS_OFS_STATE, 8'h02);
      chk("switching_en", 8'h00, {7'h0, sw_en});
      enable <= 1'h0;
      repeat (4) @(posedge clk);
      enable <= 1'h1;
      wait_sw(1'h1, 100);
      rd_chk("status", `BOCS_OFS_STATUS, 8'h00);
      conclude();
   end
endmodule
